// >>> fwb_pkg.sv
package fwb_pkg;
    // Status register address and reset value
    localparam logic [23:0] STATUS_ADDR = 24'h0e0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Status field positions
    localparam int BANK2_BUSY_BIT = 1;
    localparam int BANK3_BUSY_BIT = 2;
    localparam int LOCK_BIT = 4;
    localparam int BANK0_BUSY_BIT = 5;
    localparam int BANK1_BUSY_BIT = 6;
    // Control register window, locked while an operation runs
    localparam logic [23:0] CTRL_FIRST = 24'h0e0000;
    localparam logic [23:0] CTRL_LAST = 24'h0e0015;
    // Trap code raised on a refused read
    localparam logic [15:0] TRAP_CODE = 16'h009b;
    // Test block window in the flash map
    localparam logic [23:0] TEST_FIRST = 24'h000000;
    localparam logic [23:0] TEST_LAST = 24'h001fff;
    // Bank address windows
    localparam logic [23:0] BANK0_LAST = 24'h06ffff;
    localparam logic [23:0] BANK1_LAST = 24'h08ffff;
    localparam logic [23:0] BANK2_LAST = 24'h0bffff;
    localparam logic [23:0] BANK3_LAST = 24'h0dffff;
    // Operation sequencer states
    typedef enum logic [1:0] {FWB_IDLE, FWB_RUN, FWB_SUSP} fwb_state_e;
endpackage : fwb_pkg

// >>> fwb_bank_if.sv
`timescale 1ns/100ps
// Bank busy flags shared between the top and the access guard
interface fwb_bank_if;
    logic [3:0] busy; // Busy flag per bank
    logic lock; // Register lock flag
    modport ctrl (output busy, output lock);
    modport guard (input busy, input lock);
endinterface : fwb_bank_if

// >>> fwb_guard.sv
`timescale 1ns/100ps
// Decodes one access against busy banks, lock and test block
module fwb_guard (
    fwb_bank_if.guard bank,
    input wire logic [23:0] addr,
    input wire logic bootstrap,
    output logic in_ctrl,
    output logic blocked,
    output logic hidden
);
    logic [3:0] hit; // Bank selected by the address
    logic test_hit; // Address in test block window

    // Address decode and refusal terms
    always_comb
    begin
        hit = 4'h0;
        test_hit = (addr <= fwb_pkg::TEST_LAST);
        in_ctrl = (addr >= fwb_pkg::CTRL_FIRST) &&
                  (addr <= fwb_pkg::CTRL_LAST);
        if (addr <= fwb_pkg::BANK0_LAST)
            hit[0] = 1'b1;
        else if (addr <= fwb_pkg::BANK1_LAST)
            hit[1] = 1'b1;
        else if (addr <= fwb_pkg::BANK2_LAST)
            hit[2] = 1'b1;
        else if (addr <= fwb_pkg::BANK3_LAST)
            hit[3] = 1'b1;
        // Busy bank or locked control register refuses access
        blocked = (|(hit & bank.busy)) || (in_ctrl && bank.lock);
        // Test block hidden outside bootstrap mode
        hidden = test_hit && !bootstrap;
    end
endmodule : fwb_guard

// >>> fwb_top.sv
`timescale 1ns/100ps
// Behaviour
// - Supply drop aborts operation, banks to read
// - Refuse all writes to test block
// - Test block visible only in bootstrap
// - Read-only status register, documented bit layout
// - Start sets busy of affected narrow banks
// - Protection programming sets bank 2 busy
// - Busy bank: reads trap, writes ignored
// - Busy clears on completion or suspend
// - Resume sets busy flags again
// - Start sets busy of affected wide banks
// - Lock: control reads trap, writes ignored
// - Lock set when start bit written
// - Lock bit always readable
// - Error register updates only with all banks idle
module fwb_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start, // Operation start bit written to one
    input wire logic [3:0] start_banks, // Banks the operation touches
    input wire logic protect_op, // Protection register programming
    input wire logic op_done, // Algorithm finished
    input wire logic suspend, // Suspend request
    input wire logic resume, // Resume request
    input wire logic supply_low, // Core supply below threshold
    input wire logic bootstrap, // Chip runs in bootstrap mode
    input wire logic err_update, // Algorithm reports new error bits
    input wire logic [15:0] err_in, // New error bits
    input wire logic bus_sel, // Access strobe
    input wire logic bus_wr, // Write when high
    input wire logic [1:0] bus_be, // Byte enables
    input wire logic [23:0] bus_addr, // Access address
    output logic [15:0] bus_rdata, // Read data
    output logic trap, // Software trap pulse
    output logic [15:0] trap_code, // Trap code
    output logic write_ok, // Write may reach the array or register
    output logic [3:0] bank_read_mode, // Bank in read mode
    output logic op_abort, // Operation aborted
    output logic [15:0] error_reg // Write error register
);
    // Whole module state
    typedef struct packed {
        fwb_pkg::fwb_state_e st;
        logic [3:0] busy;
        logic [3:0] banks;
        logic lock;
        logic abort;
        logic trap;
        logic [15:0] rdata;
        logic [15:0] err;
    } fwb_state_s;

    fwb_state_s r; // Registered state
    fwb_state_s next_r; // Next state
    fwb_bank_if bank (); // Busy and lock to guard
    logic in_ctrl; // Access hits control window
    logic blocked; // Access refused
    logic hidden; // Test block hidden
    logic test_hit; // Address in test block
    logic [15:0] status; // Status word as read

    assign bank.busy = r.busy;
    assign bank.lock = r.lock;

    fwb_guard fwb_guard_inst (
        .bank(bank),
        .addr(bus_addr),
        .bootstrap(bootstrap),
        .in_ctrl(in_ctrl),
        .blocked(blocked),
        .hidden(hidden)
    );

    // Test window decode for write refusal
    assign test_hit = (bus_addr <= fwb_pkg::TEST_LAST);

    // Status word assembly, reserved bits zero
    always_comb
    begin
        status = fwb_pkg::STATUS_RESET;
        status[fwb_pkg::BANK1_BUSY_BIT] = r.busy[1];
        status[fwb_pkg::BANK0_BUSY_BIT] = r.busy[0];
        status[fwb_pkg::LOCK_BIT] = r.lock;
        status[fwb_pkg::BANK3_BUSY_BIT] = r.busy[3];
        status[fwb_pkg::BANK2_BUSY_BIT] = r.busy[2];
    end

    // Next state logic
    always_comb
    begin
        next_r = r;
        next_r.trap = 1'b0;
        next_r.abort = 1'b0;
        case (r.st)
            fwb_pkg::FWB_IDLE:
            begin
                if (start)
                begin
                    // Lock and busy rise with the start bit
                    next_r.lock = 1'b1;
                    next_r.banks = start_banks;
                    next_r.busy = start_banks;
                    if (protect_op)
                    begin
                        next_r.banks[2] = 1'b1;
                        next_r.busy[2] = 1'b1;
                    end
                    next_r.st = fwb_pkg::FWB_RUN;
                end
            end
            fwb_pkg::FWB_RUN:
            begin
                if (op_done)
                begin
                    // Completion frees banks and registers
                    next_r.busy = 4'h0;
                    next_r.lock = 1'b0;
                    next_r.st = fwb_pkg::FWB_IDLE;
                end
                else if (suspend)
                begin
                    next_r.busy = 4'h0;
                    next_r.lock = 1'b0;
                    next_r.st = fwb_pkg::FWB_SUSP;
                end
            end
            fwb_pkg::FWB_SUSP:
            begin
                if (resume)
                begin
                    next_r.busy = r.banks;
                    next_r.lock = 1'b1;
                    next_r.st = fwb_pkg::FWB_RUN;
                end
            end
            default:
            begin
                next_r.st = fwb_pkg::FWB_IDLE;
            end
        endcase
        // Error register only updates with all banks idle
        if (err_update && (next_r.busy == 4'h0))
            next_r.err = err_in;
        // Supply drop outside idle overrides the sequencer, busy, lock and banks
        if (supply_low && (r.st != fwb_pkg::FWB_IDLE))
        begin
            next_r.abort = 1'b1;
            next_r.busy = 4'h0;
            next_r.lock = 1'b0;
            next_r.banks = 4'h0;
            next_r.st = fwb_pkg::FWB_IDLE;
        end
        // Read answer
        if (bus_sel && !bus_wr)
        begin
            if (bus_addr == fwb_pkg::STATUS_ADDR)
                next_r.rdata = status;
            else if (hidden)
                next_r.rdata = 16'h0000;
            else if (blocked)
            begin
                // Busy bank or locked register: invalid data and trap
                next_r.rdata = 16'h0000;
                next_r.trap = 1'b1;
            end
            else
                next_r.rdata = 16'h0000;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.st <= fwb_pkg::FWB_IDLE;
        end
        else
            r <= next_r;
    end

    // Writes pass only when not refused; status is read-only
    assign write_ok = bus_sel && bus_wr && (|bus_be) && !blocked &&
                      !test_hit &&
                      (bus_addr != fwb_pkg::STATUS_ADDR);
    assign bus_rdata = r.rdata;
    assign trap = r.trap;
    assign trap_code = fwb_pkg::TRAP_CODE;
    assign bank_read_mode = ~r.busy;
    assign op_abort = r.abort;
    assign error_reg = r.err;

    // Start, completion, suspend and resume as taken by the sequencer
    sequence s_start_taken;
        r.st == fwb_pkg::FWB_IDLE && start && !supply_low;
    endsequence
    sequence s_done_taken;
        r.st == fwb_pkg::FWB_RUN && op_done && !supply_low;
    endsequence
    sequence s_suspend_taken;
        r.st == fwb_pkg::FWB_RUN && !op_done && suspend && !supply_low;
    endsequence
    sequence s_resume_taken;
        r.st == fwb_pkg::FWB_SUSP && resume && !supply_low;
    endsequence

    // Lock follows start one cycle later
    a_lock_on_start: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_start_taken |=> r.lock)
        else $error("lock not set on start");
    // Supply drop empties every bank and flags the abort
    a_abort_clears: assert property (
        @(posedge clk) disable iff (sys_rst)
        (supply_low && r.st != fwb_pkg::FWB_IDLE) |=>
        (r.busy == 4'h0 && !r.lock && op_abort))
        else $error("supply drop did not abort");
    // Aborted banks are back in read mode at once
    a_abort_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        op_abort |-> (bank_read_mode == 4'hf && r.st == fwb_pkg::FWB_IDLE))
        else $error("abort left a bank out of read mode");
    // Abort flag is a single-cycle pulse
    a_abort_pulse: assert property (
        @(posedge clk) disable iff (sys_rst)
        op_abort |=> !op_abort)
        else $error("abort flag held");
    // Protection programming always claims bank 2
    a_protect_bank2: assert property (
        @(posedge clk) disable iff (sys_rst)
        (s_start_taken ##0 protect_op) |=> r.busy[2])
        else $error("protection op left bank 2 idle");
    // Busy flags copy the banks the operation touches
    a_busy_start: assert property (
        @(posedge clk) disable iff (sys_rst)
        (s_start_taken ##0 !protect_op) |=> (r.busy == $past(start_banks)))
        else $error("busy flags wrong after start");
    // Completion frees every bank and the registers
    a_done_free: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_done_taken |=> (r.busy == 4'h0 && !r.lock))
        else $error("completion kept busy");
    // Suspend frees the banks and parks the sequencer
    a_suspend_free: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_suspend_taken |=> (r.busy == 4'h0 && r.st == fwb_pkg::FWB_SUSP))
        else $error("suspend kept busy");
    // Busy flags stand until completion, suspend or abort
    a_busy_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        (r.st == fwb_pkg::FWB_RUN && !op_done && !suspend && !supply_low)
        |=> (r.busy == $past(r.busy) && r.lock))
        else $error("busy dropped while running");
    // Resume restores the banks saved at start
    a_resume_busy: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_resume_taken |=> (r.busy == $past(r.banks) && r.lock))
        else $error("resume did not restore busy");
    // Refused read answers with a trap and invalid data
    a_busy_trap: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_sel && !bus_wr && blocked && !hidden &&
         bus_addr != fwb_pkg::STATUS_ADDR)
        |=> (trap && bus_rdata == 16'h0000))
        else $error("busy read without trap");
    // Writes into busy bank 0 or bank 3 are held back
    a_bank0_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_sel && bus_wr && r.busy[0] && bus_addr <= fwb_pkg::BANK0_LAST)
        |-> !write_ok)
        else $error("write passed into busy bank 0");
    a_bank3_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_sel && bus_wr && r.busy[3] && bus_addr > fwb_pkg::BANK2_LAST &&
         bus_addr <= fwb_pkg::BANK3_LAST) |-> !write_ok)
        else $error("write passed into busy bank 3");
    // Locked control registers refuse writes
    a_ctrl_locked: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_sel && bus_wr && r.lock && in_ctrl) |-> !write_ok)
        else $error("control write passed while locked");
    // Status read shows lock, bank 2 and 3 busy flags and zero reserved bits
    a_status_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_sel && !bus_wr && bus_addr == fwb_pkg::STATUS_ADDR) |=>
        (bus_rdata[fwb_pkg::LOCK_BIT] == $past(r.lock) &&
         bus_rdata[fwb_pkg::BANK2_BUSY_BIT] == $past(r.busy[2]) &&
         bus_rdata[fwb_pkg::BANK3_BUSY_BIT] == $past(r.busy[3]) &&
         bus_rdata[3] == 1'b0 && bus_rdata[0] == 1'b0 &&
         bus_rdata[15:7] == 9'h000 && !trap))
        else $error("status read wrong");
    // Status register ignores writes
    a_status_ro: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_sel && bus_wr && bus_addr == fwb_pkg::STATUS_ADDR) |-> !write_ok)
        else $error("status write passed");
    // Error register frozen while any bank stays busy
    a_err_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (r.busy != 4'h0 && next_r.busy != 4'h0) |=> $stable(error_reg))
        else $error("error register changed while busy");
    // Hidden test block answers quietly outside bootstrap
    a_hidden_quiet: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_sel && !bus_wr && !bootstrap &&
         bus_addr <= fwb_pkg::TEST_LAST) |=> (!trap && bus_rdata == 16'h0000))
        else $error("hidden test block answered");
    // Test block never takes a write
    a_test_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_addr <= fwb_pkg::TEST_LAST) |-> !write_ok)
        else $error("test block write passed");
endmodule : fwb_top

// >>> fwb_cpu_model.sv
`timescale 1ns/100ps
// Processor side of the peripheral bus, one access at a time
module fwb_cpu_model (
    input wire logic clk,
    output logic bus_sel,
    output logic bus_wr,
    output logic [1:0] bus_be,
    output logic [23:0] bus_addr,
    input wire logic [15:0] bus_rdata,
    input wire logic trap,
    input wire logic write_ok
);
    // Bus idle at time zero
    initial
    begin
        bus_sel = 1'h0;
        bus_wr = 1'h0;
        bus_be = 2'h0;
        bus_addr = 24'h0;
    end
    // Read: data and trap are registered at the taking edge and read at the next falling edge
    task automatic rd(input logic [23:0] a, output logic [15:0] d,
        output logic t);
        @(posedge clk);
        bus_sel <= 1'h1;
        bus_wr <= 1'h0;
        bus_be <= 2'h3;
        bus_addr <= a;
        @(posedge clk);
        bus_sel <= 1'h0;
        bus_addr <= ~a; // Released lines do not keep the address
        @(negedge clk);
        d = bus_rdata;
        t = trap;
    endtask : rd
    // Write: grant is combinational within the access cycle
    task automatic wr(input logic [23:0] a, input logic [1:0] be,
        output logic ok);
        @(posedge clk);
        bus_sel <= 1'h1;
        bus_wr <= 1'h1;
        bus_be <= be;
        bus_addr <= a;
        @(negedge clk);
        ok = write_ok;
        @(posedge clk);
        bus_sel <= 1'h0;
        bus_wr <= 1'h0;
        bus_addr <= ~a;
    endtask : wr
endmodule : fwb_cpu_model

// >>> flash_write_busy_lock_status_tb.sv
`timescale 1ns/100ps
// Bench comparing the block with a model of busy and lock flags
module flash_write_busy_lock_status_tb;
    logic clk = 1'h0, sys_rst = 1'h1, start = 1'h0, protect_op = 1'h0;
    logic op_done = 1'h0, suspend = 1'h0, resume = 1'h0;
    logic supply_low = 1'h0, bootstrap = 1'h0, err_update = 1'h0;
    logic [3:0] start_banks = 4'h0;
    logic [15:0] err_in = 16'h0, bus_rdata, trap_code, error_reg;
    logic bus_sel, bus_wr, trap, write_ok, op_abort;
    logic [1:0] bus_be;
    logic [23:0] bus_addr;
    logic [3:0] bank_read_mode;
    // Model state: busy, lock, saved banks, error value
    logic [3:0] m_busy = 4'h0, m_bk = 4'h0;
    logic m_lock = 1'h0;
    logic [15:0] m_err = 16'h0;
    logic [7:0] rnd = 8'h28; // Random source
    int st = 0; // 0 idle, 1 running, 2 suspended
    int fails = 0, tests_run = 0;
    logic [23:0] bank_addr [4] = '{24'h020000, 24'h070000, 24'h090000,
        24'h0c0000};
    always #12.5 clk = ~clk;
    fwb_top fwb_top_inst (.clk(clk), .sys_rst(sys_rst), .start(start),
        .start_banks(start_banks), .protect_op(protect_op),
        .op_done(op_done), .suspend(suspend), .resume(resume),
        .supply_low(supply_low), .bootstrap(bootstrap),
        .err_update(err_update), .err_in(err_in), .bus_sel(bus_sel),
        .bus_wr(bus_wr), .bus_be(bus_be), .bus_addr(bus_addr),
        .bus_rdata(bus_rdata), .trap(trap), .trap_code(trap_code),
        .write_ok(write_ok), .bank_read_mode(bank_read_mode),
        .op_abort(op_abort), .error_reg(error_reg));
    fwb_cpu_model fwb_cpu_model_inst (.clk(clk), .bus_sel(bus_sel),
        .bus_wr(bus_wr), .bus_be(bus_be), .bus_addr(bus_addr),
        .bus_rdata(bus_rdata), .trap(trap), .write_ok(write_ok));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    // Status layout: b1 at 6, b0 at 5, lock at 4, b3 at 2, b2 at 1
    function automatic logic [15:0] st_exp();
        return {9'h0, m_busy[1], m_busy[0], m_lock, 1'h0, m_busy[3],
            m_busy[2], 1'h0};
    endfunction : st_exp
    task automatic chk(input string nm, input logic [15:0] s,
        input logic [15:0] e);
        tests_run++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic complete_run();
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // Event pulse: 0 start, 1 done, 2 suspend, 3 resume, 4 supply drop
    task automatic ev(input int k);
        logic ab;
        @(posedge clk);
        {start, op_done, suspend, resume, supply_low} <= 5'(1 << (4 - k));
        start_banks <= rnd[3:0];
        protect_op <= rnd[4];
        bootstrap <= rnd[5]; // Chip mode varies between events
        @(posedge clk);
        {start, op_done, suspend, resume, supply_low} <= 5'h0;
        ab = (k == 4) && (st != 0);
        if ((k == 0 && st == 0) || (k == 3 && st == 2))
        begin
            if (k == 0)
                m_bk = rnd[3:0] | (rnd[4] ? 4'h4 : 4'h0);
            m_busy = m_bk;
            m_lock = 1'h1;
            st = 1;
        end
        else if ((k == 1 || k == 2) && st == 1 || ab)
        begin
            m_busy = 4'h0;
            m_lock = 1'h0;
            st = (k == 2) ? 2 : 0;
        end
        @(negedge clk);
        chk("abort", {15'h0, op_abort}, {15'h0, ab});
        chk("read_mode", {12'h0, bank_read_mode}, {12'h0, ~m_busy});
    endtask : ev
    // Status read; every bank and the control window, read and write
    task automatic scan();
        logic [15:0] d;
        logic t, ok;
        fwb_cpu_model_inst.rd(fwb_pkg::STATUS_ADDR, d, t);
        chk("status", d, st_exp());
        chk("status_trap", {15'h0, t}, 16'h0);
        for (int b = 0; b < 4; b++)
        begin
            fwb_cpu_model_inst.rd(bank_addr[b], d, t);
            chk("bank_trap", {15'h0, t}, {15'h0, m_busy[b]});
            chk("trap_code", trap_code, fwb_pkg::TRAP_CODE);
            fwb_cpu_model_inst.wr(bank_addr[b], 2'h3, ok);
            if (m_busy[b] || st == 0)
                chk("bank_wr", {15'h0, ok}, {15'h0, ~m_busy[b]});
        end
        fwb_cpu_model_inst.rd(fwb_pkg::TEST_FIRST, d, t);
        chk("test_trap", {15'h0, t}, {15'h0, m_busy[0] & bootstrap});
        fwb_cpu_model_inst.rd(24'h0e0008, d, t);
        chk("ctrl_trap", {15'h0, t}, {15'h0, m_lock});
        fwb_cpu_model_inst.wr(24'h0e0010, 2'h1, ok);
        chk("ctrl_wr", {15'h0, ok}, {15'h0, ~m_lock});
    endtask : scan
    // Error update is taken only with all banks idle
    task automatic err_pulse();
        @(posedge clk);
        err_update <= 1'h1;
        err_in <= {rnd, ~rnd};
        @(posedge clk);
        err_update <= 1'h0;
        if (m_busy == 4'h0)
            m_err = {rnd, ~rnd};
        @(negedge clk);
        chk("error_reg", error_reg, m_err);
    endtask : err_pulse
    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
    // Main sequence
    initial
    begin
        logic [15:0] d;
        logic t, ok;
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        @(negedge clk);
        chk("rst_mode", {12'h0, bank_read_mode}, 16'h000f);
        chk("rst_err", error_reg, 16'h0);
        scan();
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            ev(0);
            rnd = lfsr(rnd);
            ev(0); // Start while running is ignored
            scan();
            err_pulse();
            ev(2);
            scan();
            ev(3);
            scan();
            ev(i % 2 ? 4 : 1);
            scan();
            err_pulse();
        end
        // Supply drop, then power-on and the operation issued again
        rnd = lfsr(rnd);
        ev(0);
        ev(4);
        @(posedge clk);
        sys_rst <= 1'h1;
        @(posedge clk);
        sys_rst <= 1'h0;
        m_err = 16'h0;
        @(negedge clk);
        chk("rst_err", error_reg, m_err);
        ev(0);
        scan();
        ev(1);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            bootstrap <= 1'(m);
            fwb_cpu_model_inst.wr(fwb_pkg::TEST_FIRST, 2'h3, ok);
            chk("test_wr", {15'h0, ok}, 16'h0);
            fwb_cpu_model_inst.rd(fwb_pkg::TEST_FIRST, d, t);
            if (m == 0)
                chk("test_hide", {d[14:0], t}, 16'h0);
            fwb_cpu_model_inst.wr(fwb_pkg::STATUS_ADDR, 2'h3, ok);
            chk("status_wr", {15'h0, ok}, 16'h0);
            fwb_cpu_model_inst.rd(fwb_pkg::STATUS_ADDR, d, t);
            chk("status_ro", d, st_exp());
        end
        complete_run();
    end
endmodule : flash_write_busy_lock_status_tb
